/* File: bdms_core.sv */
// banked data memory, core registers and status flags
`default_nettype none
module bdms_core (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  req_valid,
  input  wire bdms_pkg::bdms_req_t   req_op,
  input  wire logic [6:0]            req_addr,
  input  wire logic [7:0]            req_wdata,
  input  wire bdms_pkg::bdms_aluop_t req_alu_op,
  input  wire logic                  req_to_w,
  input  wire logic                  req_load_w,
  input  wire logic [13:0]           pm_rdata,
  input  wire logic [7:0]            sfr_rdata,
  input  wire logic                  evt_wdt_clear,
  input  wire logic                  evt_sleep,
  input  wire logic                  evt_wdt_timeout,
  output var  logic                  req_ready,
  output var  logic                  rsp_valid,
  output var  logic [7:0]            rsp_data,
  output var  logic [7:0]            w_value,
  output var  logic [7:0]            status_value,
  output var  logic                  pm_rd,
  output var  logic [14:0]           pm_addr,
  output var  logic                  sfr_rd,
  output var  logic                  sfr_wr,
  output var  logic [11:0]           sfr_addr,
  output var  logic [7:0]            sfr_wdata
);
  bdms_pkg::bdms_core_t core_q, core_d;
  bdms_pkg::bdms_st_t   st_q, st_d;
  logic                 ready_q, ready_d;
  logic                 rv_q, rv_d;
  logic [7:0]           rdat_q, rdat_d;
  logic                 pmrd_q, pmrd_d;
  logic [14:0]          pa_q, pa_d;
  logic                 sfrrd_q, sfrrd_d;
  logic                 sfrwr_q, sfrwr_d;
  logic [11:0]          sfra_q, sfra_d;
  logic [7:0]           sfrwd_q, sfrwd_d;
  logic                 ldw_q, ldw_d;
  logic                 expm_q, expm_d;

  bdms_pkg::bdms_tgt_t  tgt;
  bdms_pkg::bdms_rgn_t  rgn;
  logic [15:0]          ptr_sel;
  logic                 is_ind;
  logic                 acc;
  logic                 dofile;
  logic                 ram_we;
  logic [7:0]           ram_rdata;
  logic [7:0]           loc_rd;
  logic [7:0]           wval;
  logic [7:0]           ext_rd;

  bdms_alu_if alu_if ();

  bdms_alu u_alu (
    .bus (alu_if.unit)
  );

  bdms_ram u_ram (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .w_bank  (tgt.bank),
    .w_off   (tgt.off),
    .wdata   (wval),
    .r_bank  (tgt.bank),
    .r_off   (tgt.off),
    .rdata   (ram_rdata)
  );

  assign alu_if.op  = req_alu_op;
  assign alu_if.a   = core_q.w;
  assign alu_if.b   = req_wdata;
  assign alu_if.cin = core_q.sts[bdms_pkg::ST_C];

  // target resolution, direct or through a pointer
  always_comb begin
    ptr_sel = req_addr[0] ? {core_q.p1h, core_q.p1l} : {core_q.p0h, core_q.p0l};
    is_ind  = (req_addr == bdms_pkg::OFF_IND0) || (req_addr == bdms_pkg::OFF_IND1);
    if (is_ind) begin
      tgt = bdms_pkg::resolve_ptr(ptr_sel);
    end else begin
      tgt      = '0;
      tgt.bank = core_q.bank_selector;
      tgt.off  = req_addr;
    end
    rgn = bdms_pkg::region_of(tgt.off);
  end

  // local read mux
  always_comb begin
    loc_rd = 8'h00;
    if (!tgt.pm && !tgt.none) begin
      case (rgn)
        bdms_pkg::RG_CORE: begin
          case (tgt.off)
            bdms_pkg::OFF_PCL:    loc_rd = core_q.program_counter_low;
            bdms_pkg::OFF_STATUS: loc_rd = core_q.sts;
            bdms_pkg::OFF_P0L:    loc_rd = core_q.p0l;
            bdms_pkg::OFF_P0H:    loc_rd = core_q.p0h;
            bdms_pkg::OFF_P1L:    loc_rd = core_q.p1l;
            bdms_pkg::OFF_P1H:    loc_rd = core_q.p1h;
            bdms_pkg::OFF_BSR:    loc_rd = {3'h0, core_q.bank_selector};
            bdms_pkg::OFF_WORKING_ACCUMULATOR:   loc_rd = core_q.w;
            bdms_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: loc_rd = core_q.program_counter_latch_high;
            bdms_pkg::OFF_INTERRUPT_CONTROL: loc_rd = core_q.interrupt_control;
            default:              loc_rd = 8'h00;
          endcase
        end
        bdms_pkg::RG_SFR: loc_rd = 8'h00;
        default:          loc_rd = ram_rdata;
      endcase
    end
  end

  assign acc    = (st_q == bdms_pkg::ST_IDLE) && req_valid;
  assign wval   = (req_op == bdms_pkg::BDMS_ALU) ? alu_if.res : req_wdata;
  assign ext_rd = expm_q ? pm_rdata[7:0] : sfr_rdata;

  always_comb begin
    core_d  = core_q;
    st_d    = st_q;
    ready_d = ready_q;
    rv_d    = 1'b0;
    rdat_d  = rdat_q;
    pmrd_d  = 1'b0;
    pa_d    = pa_q;
    sfrrd_d = 1'b0;
    sfrwr_d = 1'b0;
    sfra_d  = sfra_q;
    sfrwd_d = sfrwd_q;
    ldw_d   = ldw_q;
    expm_d  = expm_q;
    dofile  = 1'b0;
    ram_we  = 1'b0;
    case (st_q)
      bdms_pkg::ST_IDLE: begin
        if (req_valid && req_op == bdms_pkg::BDMS_RD) begin
          ldw_d = req_load_w;
          if (tgt.pm) begin
            pmrd_d  = 1'b1;
            pa_d    = tgt.pa;
            expm_d  = 1'b1;
            ready_d = 1'b0;
            st_d    = bdms_pkg::ST_EXT;
          end else if (!tgt.none && rgn == bdms_pkg::RG_SFR) begin
            sfrrd_d = 1'b1;
            sfra_d  = {tgt.bank, tgt.off};
            expm_d  = 1'b0;
            ready_d = 1'b0;
            st_d    = bdms_pkg::ST_EXT;
          end else begin
            rv_d   = 1'b1;
            rdat_d = loc_rd;
            if (req_load_w) begin
              core_d.w = loc_rd;
            end
          end
        end else if (req_valid && req_op == bdms_pkg::BDMS_ALU && req_to_w) begin
          core_d.w = alu_if.res;
        end else if (req_valid) begin
          dofile = 1'b1;
        end
      end
      bdms_pkg::ST_EXT: begin
        rv_d    = 1'b1;
        rdat_d  = ext_rd;
        ready_d = 1'b1;
        st_d    = bdms_pkg::ST_IDLE;
        if (ldw_q) begin
          core_d.w = ext_rd;
        end
      end
      default: st_d = bdms_pkg::ST_IDLE;
    endcase

    // file write; program memory targets are dropped
    if (dofile && !tgt.pm && !tgt.none) begin
      case (rgn)
        bdms_pkg::RG_CORE: begin
          case (tgt.off)
            bdms_pkg::OFF_PCL:    core_d.program_counter_low = wval;
            bdms_pkg::OFF_STATUS: begin
              if (req_op != bdms_pkg::BDMS_ALU || alu_if.aff == bdms_pkg::AFF_NONE) begin
                core_d.sts[2:0] = wval[2:0];
              end
            end
            bdms_pkg::OFF_P0L:    core_d.p0l = wval;
            bdms_pkg::OFF_P0H:    core_d.p0h = wval;
            bdms_pkg::OFF_P1L:    core_d.p1l = wval;
            bdms_pkg::OFF_P1H:    core_d.p1h = wval;
            bdms_pkg::OFF_BSR:    core_d.bank_selector = wval[4:0];
            bdms_pkg::OFF_WORKING_ACCUMULATOR:   core_d.w = wval;
            bdms_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH: core_d.program_counter_latch_high = wval;
            bdms_pkg::OFF_INTERRUPT_CONTROL: core_d.interrupt_control = wval;
            default:              core_d.program_counter_low = core_q.program_counter_low;
          endcase
        end
        bdms_pkg::RG_SFR: begin
          sfrwr_d = 1'b1;
          sfra_d  = {tgt.bank, tgt.off};
          sfrwd_d = wval;
        end
        default: ram_we = 1'b1;
      endcase
    end

    // flags from the alu win over the register write
    if (acc && req_op == bdms_pkg::BDMS_ALU) begin
      if ((alu_if.aff & bdms_pkg::AFF_Z) != bdms_pkg::AFF_NONE) begin
        core_d.sts[bdms_pkg::ST_Z] = alu_if.z;
      end
      if ((alu_if.aff & bdms_pkg::AFF_DC) != bdms_pkg::AFF_NONE) begin
        core_d.sts[bdms_pkg::ST_DC] = alu_if.dc;
      end
      if ((alu_if.aff & bdms_pkg::AFF_C) != bdms_pkg::AFF_NONE) begin
        core_d.sts[bdms_pkg::ST_C] = alu_if.c;
      end
    end

    // reset-cause flags, timeout applied last
    if (evt_wdt_clear) begin
      core_d.sts[bdms_pkg::ST_TO] = 1'b1;
      core_d.sts[bdms_pkg::ST_PD] = 1'b1;
    end
    if (evt_sleep) begin
      core_d.sts[bdms_pkg::ST_TO] = 1'b1;
      core_d.sts[bdms_pkg::ST_PD] = 1'b0;
    end
    if (evt_wdt_timeout) begin
      core_d.sts[bdms_pkg::ST_TO] = 1'b0;
    end
    core_d.sts[7:5] = 3'h0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      core_q     <= '0;
      core_q.sts <= bdms_pkg::STS_RST;
      st_q       <= bdms_pkg::ST_IDLE;
      ready_q    <= 1'b1;
      rv_q       <= 1'b0;
      rdat_q     <= 8'h00;
      pmrd_q     <= 1'b0;
      pa_q       <= 15'h0000;
      sfrrd_q    <= 1'b0;
      sfrwr_q    <= 1'b0;
      sfra_q     <= 12'h000;
      sfrwd_q    <= 8'h00;
      ldw_q      <= 1'b0;
      expm_q     <= 1'b0;
    end else begin
      core_q  <= core_d;
      st_q    <= st_d;
      ready_q <= ready_d;
      rv_q    <= rv_d;
      rdat_q  <= rdat_d;
      pmrd_q  <= pmrd_d;
      pa_q    <= pa_d;
      sfrrd_q <= sfrrd_d;
      sfrwr_q <= sfrwr_d;
      sfra_q  <= sfra_d;
      sfrwd_q <= sfrwd_d;
      ldw_q   <= ldw_d;
      expm_q  <= expm_d;
    end
  end

  assign req_ready    = ready_q;
  assign rsp_valid    = rv_q;
  assign rsp_data     = rdat_q;
  assign w_value      = core_q.w;
  assign status_value = core_q.sts;
  assign pm_rd        = pmrd_q;
  assign pm_addr      = pa_q;
  assign sfr_rd       = sfrrd_q;
  assign sfr_wr       = sfrwr_q;
  assign sfr_addr     = sfra_q;
  assign sfr_wdata    = sfrwd_q;

  // checks
  logic [7:0] pm_lo;
  logic [4:0] wb5;
  logic [7:0] w_cur;
  logic [6:0] off_cur;
  logic [2:0] flg;
  logic [1:0] to_pd;
  logic       quiet;
  assign pm_lo   = pm_rdata[7:0];
  assign wb5     = req_wdata[4:0];
  assign w_cur   = core_q.w;
  assign off_cur = tgt.off;
  assign flg     = {alu_if.z, alu_if.dc, alu_if.c};
  assign to_pd   = core_q.sts[4:3];
  assign quiet   = !evt_wdt_clear && !evt_sleep && !evt_wdt_timeout;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_pm_fetch_delay: assert property (acc && req_op == bdms_pkg::BDMS_RD && tgt.pm
    |=> pmrd_q && !rv_q ##1 rv_q) else $error("program memory read timing wrong");
  a_ready_wait: assert property (acc && req_op == bdms_pkg::BDMS_RD && tgt.pm
    |=> !ready_q ##1 ready_q) else $error("program memory wait cycle missing");
  a_pm_low_byte: assert property (st_q == bdms_pkg::ST_EXT && expm_q && ldw_q
    |=> w_cur == $past(pm_lo)) else $error("accumulator not loaded with low byte");
  a_pm_no_write: assert property (acc && req_op != bdms_pkg::BDMS_RD && tgt.pm
    |-> !ram_we ##1 !sfrwr_q) else $error("write reached program memory target");
  a_bank_follow: assert property (acc && req_op == bdms_pkg::BDMS_WR && !is_ind
    && req_addr == bdms_pkg::OFF_BSR |=> core_q.bank_selector == $past(wb5)) else $error("bank not updated");
  a_unimpl_zero: assert property (acc && req_op == bdms_pkg::BDMS_RD && tgt.none
    |=> rv_q && rdat_q == 8'h00) else $error("unimplemented read not zero");
  a_core_w_mirror: assert property (acc && req_op == bdms_pkg::BDMS_RD && !is_ind
    && req_addr == bdms_pkg::OFF_WORKING_ACCUMULATOR |=> rdat_q == $past(w_cur)) else $error("core read mismatch");
  a_sfr_decode: assert property (acc && req_op == bdms_pkg::BDMS_RD && !tgt.pm && !tgt.none
    && rgn == bdms_pkg::RG_SFR |=> sfrrd_q && sfra_q[6:0] == $past(off_cur) ##1 rv_q)
    else $error("peripheral read not issued");
  a_sfr_write: assert property (acc && req_op == bdms_pkg::BDMS_WR && !tgt.pm && !tgt.none
    && rgn == bdms_pkg::RG_SFR |=> sfrwr_q && sfrwd_q == $past(req_wdata))
    else $error("peripheral write not issued");
  a_status_flags: assert property (acc && req_op == bdms_pkg::BDMS_ALU && !req_to_w && !is_ind
    && req_addr == bdms_pkg::OFF_STATUS && (req_alu_op == bdms_pkg::BDMS_ADD || req_alu_op == bdms_pkg::BDMS_SUB)
    |=> core_q.sts[2:0] == $past(flg)) else $error("status flags took written value");
  a_status_protect: assert property (acc && req_op == bdms_pkg::BDMS_WR && !is_ind
    && req_addr == bdms_pkg::OFF_STATUS && quiet |=> $stable(to_pd) && core_q.sts[7:5] == 3'h0)
    else $error("protected status bits changed");
  a_sleep_flags: assert property (evt_sleep && !evt_wdt_timeout
    |=> to_pd == 2'h2) else $error("sleep flags wrong");
  a_timeout_flag: assert property (evt_wdt_timeout |=> !core_q.sts[bdms_pkg::ST_TO])
    else $error("timeout flag not cleared");

  c_pm_read: cover property (acc && req_op == bdms_pkg::BDMS_RD && tgt.pm && req_load_w);
  c_sfr_read: cover property (acc && req_op == bdms_pkg::BDMS_RD && rgn == bdms_pkg::RG_SFR);
  c_alu_status: cover property (acc && req_op == bdms_pkg::BDMS_ALU && req_addr == bdms_pkg::OFF_STATUS);
  c_sleep: cover property (evt_sleep);
  c_sfr_write: cover property (acc && req_op == bdms_pkg::BDMS_WR && rgn == bdms_pkg::RG_SFR);
endmodule : bdms_core
`default_nettype wire

/* File: bdms_pkg.sv */
// constants, types and decode helpers for the banked data memory
`default_nettype none
package bdms_pkg;
  localparam int         BANK_BITS   = 5;
  localparam int         GP_PER_BANK = 80;
  localparam int         GP_TOTAL    = 2560;
  localparam int         COM_SZ      = 16;
  localparam logic [6:0] OFF_IND0    = 7'h00;
  localparam logic [6:0] OFF_IND1    = 7'h01;
  localparam logic [6:0] OFF_PCL     = 7'h02;
  localparam logic [6:0] OFF_STATUS  = 7'h03;
  localparam logic [6:0] OFF_P0L     = 7'h04;
  localparam logic [6:0] OFF_P0H     = 7'h05;
  localparam logic [6:0] OFF_P1L     = 7'h06;
  localparam logic [6:0] OFF_P1H     = 7'h07;
  localparam logic [6:0] OFF_BSR     = 7'h08;
  localparam logic [6:0] OFF_WORKING_ACCUMULATOR    = 7'h09;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LATCH_HIGH  = 7'h0a;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL  = 7'h0b;
  localparam logic [6:0] SFR_BASE    = 7'h0c;
  localparam logic [6:0] GP_BASE     = 7'h20;
  localparam logic [6:0] COM_BASE    = 7'h70;
  localparam logic [15:0] TRAD_LIMIT = 16'h1000;
  localparam logic [15:0] LIN_BASE   = 16'h2000;
  localparam logic [15:0] LIN_LIMIT  = 16'h2a00;
  localparam int         PTR_PM_BIT  = 15;
  localparam int         ST_TO       = 4;
  localparam int         ST_PD       = 3;
  localparam int         ST_Z        = 2;
  localparam int         ST_DC       = 1;
  localparam int         ST_C        = 0;
  localparam logic [7:0] STS_RST     = 8'h18;
  localparam logic [2:0] AFF_Z       = 3'h4;
  localparam logic [2:0] AFF_DC      = 3'h2;
  localparam logic [2:0] AFF_C       = 3'h1;
  localparam logic [2:0] AFF_NONE    = 3'h0;

  typedef enum logic [1:0] {BDMS_RD, BDMS_WR, BDMS_ALU} bdms_req_t;
  typedef enum logic [2:0] {BDMS_ADD, BDMS_SUB, BDMS_AND, BDMS_IOR,
                            BDMS_XOR, BDMS_MOV, BDMS_ROTL, BDMS_ROTR} bdms_aluop_t;
  typedef enum logic [1:0] {RG_CORE, RG_SFR, RG_GP, RG_COM} bdms_rgn_t;
  typedef enum logic {ST_IDLE, ST_EXT} bdms_st_t;

  typedef struct packed {
    logic        pm;
    logic        none;
    logic [4:0]  bank;
    logic [6:0]  off;
    logic [14:0] pa;
  } bdms_tgt_t;

  typedef struct packed {
    logic [7:0] program_counter_low;
    logic [7:0] sts;
    logic [7:0] p0l;
    logic [7:0] p0h;
    logic [7:0] p1l;
    logic [7:0] p1h;
    logic [4:0] bank_selector;
    logic [7:0] w;
    logic [7:0] program_counter_latch_high;
    logic [7:0] interrupt_control;
  } bdms_core_t;

  function automatic bdms_rgn_t region_of(input logic [6:0] off);
    if (off < SFR_BASE) return RG_CORE;
    if (off < GP_BASE) return RG_SFR;
    if (off < COM_BASE) return RG_GP;
    return RG_COM;
  endfunction : region_of

  function automatic logic [11:0] gp_index(input logic [4:0] bank, input logic [6:0] off);
    return 12'(int'(bank) * GP_PER_BANK + int'(off - GP_BASE));
  endfunction : gp_index

  function automatic bdms_tgt_t resolve_ptr(input logic [15:0] p);
    bdms_tgt_t   t;
    logic [15:0] n;
    t = '0;
    n = p - LIN_BASE;
    if (p[PTR_PM_BIT]) begin
      t.pm = 1'b1;
      t.pa = p[14:0];
    end else if (p < TRAD_LIMIT) begin
      {t.bank, t.off} = p[11:0];
    end else if (p >= LIN_BASE && p < LIN_LIMIT) begin
      t.bank = 5'(int'(n) / GP_PER_BANK);
      t.off  = 7'(int'(GP_BASE) + int'(n) % GP_PER_BANK);
    end else begin
      t.none = 1'b1;
    end
    return t;
  endfunction : resolve_ptr
endpackage : bdms_pkg
`default_nettype wire

/* File: bdms_alu_if.sv */
// operand and flag carrier between core and alu
`default_nettype none
interface bdms_alu_if;
  bdms_pkg::bdms_aluop_t op;
  logic [7:0]            a;
  logic [7:0]            b;
  logic [7:0]            res;
  logic                  cin;
  logic                  z;
  logic                  dc;
  logic                  c;
  logic [2:0]            aff;
  modport core (output op, a, b, cin, input res, z, dc, c, aff);
  modport unit (input op, a, b, cin, output res, z, dc, c, aff);
endinterface : bdms_alu_if
`default_nettype wire

/* File: bdms_alu.sv */
// result and flag computation
`default_nettype none
module bdms_alu (
  bdms_alu_if.unit bus
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum     = 9'h000;
    nib     = 5'h00;
    bus.res = bus.b;
    bus.c   = 1'b0;
    bus.dc  = 1'b0;
    bus.aff = bdms_pkg::AFF_Z;
    case (bus.op)
      bdms_pkg::BDMS_ADD: begin
        sum     = {1'b0, bus.b} + {1'b0, bus.a};
        nib     = {1'b0, bus.b[3:0]} + {1'b0, bus.a[3:0]};
        bus.aff = bdms_pkg::AFF_Z | bdms_pkg::AFF_DC | bdms_pkg::AFF_C;
      end
      bdms_pkg::BDMS_SUB: begin
        sum     = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
        nib     = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
        bus.aff = bdms_pkg::AFF_Z | bdms_pkg::AFF_DC | bdms_pkg::AFF_C;
      end
      bdms_pkg::BDMS_AND: bus.res = bus.a & bus.b;
      bdms_pkg::BDMS_IOR: bus.res = bus.a | bus.b;
      bdms_pkg::BDMS_XOR: bus.res = bus.a ^ bus.b;
      bdms_pkg::BDMS_ROTL: begin
        bus.res = {bus.b[6:0], bus.cin};
        bus.c   = bus.b[7];
        bus.aff = bdms_pkg::AFF_C;
      end
      bdms_pkg::BDMS_ROTR: begin
        bus.res = {bus.cin, bus.b[7:1]};
        bus.c   = bus.b[0];
        bus.aff = bdms_pkg::AFF_C;
      end
      default: bus.res = bus.b;
    endcase
    if (bus.op == bdms_pkg::BDMS_ADD || bus.op == bdms_pkg::BDMS_SUB) begin
      bus.res = sum[7:0];
      bus.c   = sum[8];
      bus.dc  = nib[4];
    end
    bus.z = (bus.res == 8'h00);
  end
endmodule : bdms_alu
`default_nettype wire

/* File: bdms_ram.sv */
// general and common ram storage
`default_nettype none
module bdms_ram (
  input  wire logic       clk_sys,
  input  wire logic       we,
  input  wire logic [4:0] w_bank,
  input  wire logic [6:0] w_off,
  input  wire logic [7:0] wdata,
  input  wire logic [4:0] r_bank,
  input  wire logic [6:0] r_off,
  output var  logic [7:0] rdata
);
  logic [7:0] gp_mem  [0:bdms_pkg::GP_TOTAL-1];
  logic [7:0] com_mem [0:bdms_pkg::COM_SZ-1];

  always_ff @(posedge clk_sys) begin
    if (we && bdms_pkg::region_of(w_off) == bdms_pkg::RG_COM) begin
      com_mem[w_off[3:0]] <= wdata;
    end else if (we && bdms_pkg::region_of(w_off) == bdms_pkg::RG_GP) begin
      gp_mem[bdms_pkg::gp_index(w_bank, w_off)] <= wdata;
    end
  end

  always_comb begin
    case (bdms_pkg::region_of(r_off))
      bdms_pkg::RG_COM: rdata = com_mem[r_off[3:0]];
      bdms_pkg::RG_GP:  rdata = gp_mem[bdms_pkg::gp_index(r_bank, r_off)];
      default:          rdata = 8'h00;
    endcase
  end
endmodule : bdms_ram
`default_nettype wire

/* File: bdms_mem_model.sv */
// program memory and peripheral read model
`default_nettype none
module bdms_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        pm_rd,
  input  wire logic [14:0] pm_addr,
  input  wire logic        sfr_rd,
  input  wire logic [11:0] sfr_addr,
  output var  logic [13:0] pm_rdata,
  output var  logic [7:0]  sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic t_q = 1'b0;
  always @(posedge clk_sys) t_q <= ~t_q;
  // data valid only while selected, toggling junk otherwise
  assign pm_rdata  = pm_rd ? {6'h15, pm_addr[7:0] ^ 8'h5a} : {14{t_q}};
  assign sfr_rdata = sfr_rd ? sfr_addr[7:0] ^ 8'ha5 : {8{t_q}};
endmodule : bdms_mem_model
`default_nettype wire

/* File: banked_data_memory_status_tb_top.sv */
// self-checking bench for the banked data memory
`default_nettype none
module banked_data_memory_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  logic                  req_valid = 1'b0;
  logic                  req_to_w = 1'b0;
  logic                  req_load_w = 1'b0;
  bdms_pkg::bdms_req_t   req_op = bdms_pkg::BDMS_RD;
  bdms_pkg::bdms_aluop_t req_alu_op = bdms_pkg::BDMS_MOV;
  logic [6:0]            req_addr = 7'h00;
  logic [7:0]            req_wdata = 8'h00;
  logic [2:0]            evt_q = 3'h0;
  logic [13:0]           pm_rdata;
  logic [7:0]            sfr_rdata, rsp_data, w_value, status_value, sfr_wdata, rd_q;
  logic                  req_ready, rsp_valid, pm_rd, sfr_rd, sfr_wr;
  logic [14:0]           pm_addr;
  logic [11:0]           sfr_addr;
  int                    errors = 0;
  int                    n_tests = 0;
  int                    lat;
  // alu table: op, operand, expected w, expected status
  logic [27:0] alu_t [11] = '{28'h0_01_10_1a, 28'h0_f0_00_1d, 28'h5_01_01_19, 28'h1_00_ff_18,
    28'h5_01_01_18, 28'h1_05_04_1b, 28'h6_80_01_1b, 28'h7_02_81_1a, 28'h2_f0_80_1a,
    28'h4_80_00_1e, 28'h3_05_05_1a};

  bdms_core DUT (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_alu_op(req_alu_op), .req_to_w(req_to_w),
    .req_load_w(req_load_w), .pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata), .evt_wdt_clear(evt_q[0]),
    .evt_sleep(evt_q[1]), .evt_wdt_timeout(evt_q[2]), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .w_value(w_value), .status_value(status_value), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata));
  bdms_mem_model u_mem (.clk_sys(clk_sys), .pm_rd(pm_rd), .pm_addr(pm_addr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic go(input bdms_pkg::bdms_req_t op, input logic [6:0] a, input logic [7:0] d,
                    input bdms_pkg::bdms_aluop_t ao, input logic tw, input logic lw);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        report_and_stop();
      end
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    req_alu_op <= ao;
    req_to_w <= tw;
    req_load_w <= lw;
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask : go

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    go(bdms_pkg::BDMS_WR, a, d, bdms_pkg::BDMS_MOV, 1'b0, 1'b0);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic lw);
    go(bdms_pkg::BDMS_RD, a, 8'h00, bdms_pkg::BDMS_MOV, 1'b0, lw);
    lat = 0;
    do begin
      @(negedge clk_sys);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 5);
    if (lat >= 5) begin
      errors++;
      report_and_stop();
    end
    rd_q = rsp_data;
  endtask : rd

  task automatic ev(input int k, input logic [7:0] e);
    @(posedge clk_sys);
    evt_q <= 3'(1 << k);
    @(posedge clk_sys);
    evt_q <= 3'h0;
    @(negedge clk_sys);
    chk("status_event", e, status_value);
  endtask : ev

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk("status_reset", 8'h18, status_value);
    $display("test reset done");
    wr(7'h08, 8'h03);
    wr(7'h20, 8'h11);
    wr(7'h08, 8'h04);
    wr(7'h20, 8'h22);
    wr(7'h70, 8'h33);
    wr(7'h08, 8'h03);
    rd(7'h20, 1'b0);
    chk("gp_bank3", 8'h11, rd_q);
    chk("local_latency", 8'h01, 8'(lat));
    rd(7'h70, 1'b0);
    chk("common", 8'h33, rd_q);
    rd(7'h08, 1'b0);
    chk("bank_sel", 8'h03, rd_q);
    rd(7'h0c, 1'b0);
    chk("sfr_data", 8'h29, rd_q);
    chk("sfr_bank", 8'h01, {4'h0, sfr_addr[11:8]});
    wr(7'h0d, 8'h5c);
    @(negedge clk_sys);
    chk("sfr_wr", 8'h01, {7'h00, sfr_wr});
    chk("sfr_wdata", 8'h5c, sfr_wdata);
    chk("sfr_waddr", 8'h8d, sfr_addr[7:0]);
    $display("test banks done");
    wr(7'h05, 8'h20);
    wr(7'h04, 8'h50);
    wr(7'h00, 8'h44);
    wr(7'h08, 8'h01);
    rd(7'h20, 1'b0);
    chk("linear", 8'h44, rd_q);
    wr(7'h05, 8'h15);
    rd(7'h00, 1'b0);
    chk("unimpl", 8'h00, rd_q);
    wr(7'h07, 8'h81);
    wr(7'h06, 8'h23);
    wr(7'h01, 8'hee);
    rd(7'h01, 1'b1);
    chk("pm_data", 8'h79, rd_q);
    chk("pm_w", 8'h79, w_value);
    chk("pm_latency", 8'h02, 8'(lat));
    chk("pm_addr_lo", 8'h23, pm_addr[7:0]);
    chk("pm_addr_hi", 8'h01, {1'b0, pm_addr[14:8]});
    $display("test pointers done");
    wr(7'h09, 8'h0f);
    rd(7'h09, 1'b0);
    chk("w_read", 8'h0f, rd_q);
    for (int i = 0; i < 11; i++) begin
      go(bdms_pkg::BDMS_ALU, 7'h20, alu_t[i][23:16], bdms_pkg::bdms_aluop_t'(alu_t[i][26:24]), 1'b1, 1'b0);
      @(negedge clk_sys);
      chk("alu_w", alu_t[i][15:8], w_value);
      chk("alu_status", alu_t[i][7:0], status_value);
    end
    go(bdms_pkg::BDMS_ALU, 7'h03, 8'h00, bdms_pkg::BDMS_MOV, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk("status_dest", 8'h1e, status_value);
    go(bdms_pkg::BDMS_ALU, 7'h03, 8'h01, bdms_pkg::BDMS_ADD, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk("status_add", 8'h18, status_value);
    chk("status_add_w", 8'h05, w_value);
    wr(7'h03, 8'hff);
    @(negedge clk_sys);
    chk("status_write", 8'h1f, status_value);
    $display("test alu done");
    ev(1, 8'h17);
    ev(2, 8'h07);
    ev(0, 8'h1f);
    $display("test events done");
    report_and_stop();
  end
endmodule : banked_data_memory_status_tb_top
`default_nettype wire
